// File: mmd_pkg.sv
/*
 * mmd_pkg: constants for the memory map decode and expansion bus block.
 * Assumes a single core clock and byte-wide special function registers.
 */
package mmd_pkg;
   // special function register addresses
   localparam logic [7:0] SFR_PTR0_LO = 8'h82;
   localparam logic [7:0] SFR_PTR0_HI = 8'h83;
   localparam logic [7:0] SFR_PTR1_LO = 8'h84;
   localparam logic [7:0] SFR_PTR1_HI = 8'h85;
   localparam logic [7:0] SFR_PTR_SEL = 8'h86;
   localparam logic [7:0] SFR_PAGE = 8'h92;
   localparam logic [7:0] SFR_RESET_VAL = 8'h00;
   localparam int PTR_SEL_BIT = 0;
   // memory map
   localparam logic [15:0] RAM_LO = 16'h0000;
   localparam logic [15:0] RAM_HI = 16'h1b3f;
   localparam logic [15:0] ALIAS_LO = 16'h1b40;
   localparam logic [15:0] ALIAS_HI = 16'h1fff;
   localparam logic [15:0] ISO_LO = 16'h2000;
   localparam logic [15:0] ISO_HI = 16'h27ff;
   localparam logic [15:0] BULK_LO = 16'h7b40;
   localparam logic [15:0] BULK_HI = 16'h7f3f;
   localparam logic [15:0] CTRL_LO = 16'h7f40;
   localparam logic [15:0] CTRL_HI = 16'h7fff;
   localparam logic [15:0] ISO_CTRL_ADDR = 16'h7fa1;
   localparam int ISO_DIS_BIT = 0;
   localparam logic ISO_DIS_RESET = 1'b0;
   // one bus cycle is four clocks; an access is two bus cycles
   localparam int CLOCKS_PER_CYCLE = 4;
   localparam int CYCLES_PER_ACCESS = 2;
   localparam int BOOT_WAIT = 3;
   typedef enum logic [1:0] {
      MMD_ADDR_DIRECT,
      MMD_ADDR_POINTER,
      MMD_ADDR_PAGED
   } mmd_mode_type;
   typedef enum logic [2:0] {
      MMD_REG_EXT,
      MMD_REG_RAM,
      MMD_REG_BULK,
      MMD_REG_CTRL,
      MMD_REG_ISO
   } mmd_region_type;
endpackage : mmd_pkg

// File: mmd_bus.sv
/*
 * mmd_bus: address decode, expansion bus strobes, data pointers and
 * core reset hold for the processor core.
 * Assumes the core, the sfr port and the internal memories share clock;
 * the strap, code select and external data pins are asynchronous.
 */
// Notes on behaviour
// - low ram 0000-1b3f decoded internal
// - code select pin picks low code source
// - select low: code and data share ram
// - select high: every code fetch goes external
// - bulk buffers mapped at 7b40-7f3f
// - control registers mapped at 7f40-7fff
// - 8k variant aliases buffers at 1b40-1f3f
// - iso disable maps fifo ram 2000-27ff
// - iso disable bit resets to zero
// - separate 16-bit address, 8-bit data, no latch
// - core sole master, address output only
// - each byte moves in eight clocks
// - read/write strobes share port c pins
// - fetch, read, write strobes by access kind
// - core reset driven by host bit
// - core held after power-up until host clears
// - nonvolatile boot releases core automatically
// - page byte supplies paged high address
// - pointer select lsb picks data pointer
// - no read/write strobes for internal addresses
// - select and output enable combine strobes
// - select low: no fetch strobe below 1b40
// - iso disable suppresses data strobes at 2000-27ff
`timescale 1ns/100ps
`default_nettype none
module mmd_bus #(
   parameter bit RAM_8K = 1'b1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic external_code_select,
   input wire logic nvm_boot_strap,
   input wire logic expansion_enable,
   input wire logic port_c_bit_seven,
   input wire logic port_c_bit_six,
   input wire logic host_hold_write,
   input wire logic host_hold_value,
   input wire logic core_req,
   input wire logic core_code,
   input wire logic core_write,
   input wire logic [1:0] core_mode,
   input wire logic [15:0] core_addr,
   input wire logic [7:0] core_wdata,
   output logic core_busy,
   output logic core_ack,
   output logic [7:0] core_rdata,
   output logic core_reset,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic int_req,
   output logic int_we,
   output logic [2:0] int_region,
   output logic [15:0] int_addr,
   output logic [7:0] int_wdata,
   input wire logic [7:0] int_rdata,
   output logic iso_disable_bit,
   output logic [15:0] ext_addr,
   output logic [7:0] ext_data_out,
   output logic ext_data_oe,
   input wire logic [7:0] ext_data_in,
   output logic code_fetch_strobe_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic chip_select_n,
   output logic output_enable_n
);
   localparam int ACC_CLOCKS =
      mmd_pkg::CLOCKS_PER_CYCLE * mmd_pkg::CYCLES_PER_ACCESS;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STROBE} mmd_state_type;

   mmd_state_type state_reg;
   logic [1:0] cnt_reg;
   logic ea_s1_reg, ea_s2_reg, nvm_s1_reg, nvm_s2_reg;
   logic [7:0] din_s1_reg, din_s2_reg;
   logic [7:0] ptr0_lo_reg, ptr0_hi_reg, ptr1_lo_reg, ptr1_hi_reg;
   logic [7:0] ptr_sel_reg, page_reg;
   logic is_code_reg, is_wr_reg, is_ext_reg;
   logic [2:0] region_reg;
   logic [15:0] acc_addr_reg;
   logic [7:0] acc_wdata_reg;
   logic [1:0] boot_cnt_reg;
   logic boot_done_reg;
   logic [15:0] eff_addr;
   logic [2:0] eff_region;
   logic pins_on;

   function automatic logic in_rng(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   // pin inputs pass two flops before use
   always_ff @(posedge clock) begin
      ea_s1_reg <= external_code_select;
      ea_s2_reg <= ea_s1_reg;
      nvm_s1_reg <= nvm_boot_strap;
      nvm_s2_reg <= nvm_s1_reg;
      din_s1_reg <= ext_data_in;
      din_s2_reg <= din_s1_reg;
   end

   // effective address of the access being requested
   always_comb begin
      eff_addr = core_addr;
      if (core_mode == mmd_pkg::MMD_ADDR_POINTER) begin
         if (ptr_sel_reg[mmd_pkg::PTR_SEL_BIT]) begin
            eff_addr = {ptr1_hi_reg, ptr1_lo_reg};
         end else begin
            eff_addr = {ptr0_hi_reg, ptr0_lo_reg};
         end
      end else if (core_mode == mmd_pkg::MMD_ADDR_PAGED) begin
         eff_addr = {page_reg, core_addr[7:0]};
      end
   end

   // decode: code fetches consult the code select pin, data does not
   always_comb begin
      eff_region = mmd_pkg::MMD_REG_EXT;
      if (core_code) begin
         if (!ea_s2_reg && in_rng(eff_addr, mmd_pkg::RAM_LO,
                                  mmd_pkg::RAM_HI)) begin
            eff_region = mmd_pkg::MMD_REG_RAM;
         end
         // select high leaves every fetch external
      end else if (in_rng(eff_addr, mmd_pkg::RAM_LO, mmd_pkg::RAM_HI)) begin
         eff_region = mmd_pkg::MMD_REG_RAM;
      end else if (RAM_8K && in_rng(eff_addr, mmd_pkg::ALIAS_LO,
                                    mmd_pkg::ALIAS_HI)) begin
         // alias also covers 1f40-1fff so nothing leaks outside
         eff_region = mmd_pkg::MMD_REG_BULK;
      end else if (iso_disable_bit && in_rng(eff_addr, mmd_pkg::ISO_LO,
                                             mmd_pkg::ISO_HI)) begin
         eff_region = mmd_pkg::MMD_REG_ISO;
      end else if (in_rng(eff_addr, mmd_pkg::BULK_LO, mmd_pkg::BULK_HI)) begin
         eff_region = mmd_pkg::MMD_REG_BULK;
      end else if (in_rng(eff_addr, mmd_pkg::CTRL_LO, mmd_pkg::CTRL_HI)) begin
         eff_region = mmd_pkg::MMD_REG_CTRL;
      end
   end

   // access sequencer: address cycle then strobe cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
         is_code_reg <= 1'b0;
         is_wr_reg <= 1'b0;
         is_ext_reg <= 1'b0;
         region_reg <= mmd_pkg::MMD_REG_EXT;
         acc_addr_reg <= 16'h0000;
         acc_wdata_reg <= 8'h00;
         core_busy <= 1'b0;
         core_ack <= 1'b0;
         core_rdata <= 8'h00;
         int_req <= 1'b0;
         int_we <= 1'b0;
      end else begin
         core_ack <= 1'b0;
         int_req <= 1'b0;
         int_we <= 1'b0;
         cnt_reg <= cnt_reg + 2'h1;
         unique case (state_reg)
            ST_IDLE: begin
               cnt_reg <= 2'h0;
               if (core_req && !core_reset) begin
                  state_reg <= ST_ADDR;
                  core_busy <= 1'b1;
                  is_code_reg <= core_code;
                  is_wr_reg <= core_write && !core_code;
                  region_reg <= eff_region;
                  is_ext_reg <= eff_region == mmd_pkg::MMD_REG_EXT;
                  acc_addr_reg <= eff_addr;
                  acc_wdata_reg <= core_wdata;
               end
            end
            ST_ADDR: begin
               if (cnt_reg == 2'h3) begin
                  state_reg <= ST_STROBE;
                  int_req <= !is_ext_reg;
                  int_we <= !is_ext_reg && is_wr_reg;
               end
            end
            ST_STROBE: begin
               if (cnt_reg == 2'h3) begin
                  state_reg <= ST_IDLE;
                  core_busy <= 1'b0;
                  core_ack <= 1'b1;
                  if (is_ext_reg) begin
                     core_rdata <= din_s2_reg;
                  end else if (acc_addr_reg == mmd_pkg::ISO_CTRL_ADDR) begin
                     core_rdata <= {7'h00, iso_disable_bit};
                  end else begin
                     core_rdata <= int_rdata;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         int_region <= mmd_pkg::MMD_REG_EXT;
         int_addr <= 16'h0000;
         int_wdata <= 8'h00;
      end else begin
         int_region <= region_reg;
         int_addr <= acc_addr_reg;
         int_wdata <= acc_wdata_reg;
      end
   end

   // iso control register lives in the control register window
   always_ff @(posedge clock) begin
      if (rst) begin
         iso_disable_bit <= mmd_pkg::ISO_DIS_RESET;
      end else if (int_we && int_addr == mmd_pkg::ISO_CTRL_ADDR) begin
         iso_disable_bit <= int_wdata[mmd_pkg::ISO_DIS_BIT];
      end
   end

   // special function registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ptr0_lo_reg <= mmd_pkg::SFR_RESET_VAL;
         ptr0_hi_reg <= mmd_pkg::SFR_RESET_VAL;
         ptr1_lo_reg <= mmd_pkg::SFR_RESET_VAL;
         ptr1_hi_reg <= mmd_pkg::SFR_RESET_VAL;
         ptr_sel_reg <= mmd_pkg::SFR_RESET_VAL;
         page_reg <= mmd_pkg::SFR_RESET_VAL;
      end else if (sfr_write) begin
         unique case (sfr_addr)
            mmd_pkg::SFR_PTR0_LO: ptr0_lo_reg <= sfr_wdata;
            mmd_pkg::SFR_PTR0_HI: ptr0_hi_reg <= sfr_wdata;
            mmd_pkg::SFR_PTR1_LO: ptr1_lo_reg <= sfr_wdata;
            mmd_pkg::SFR_PTR1_HI: ptr1_hi_reg <= sfr_wdata;
            mmd_pkg::SFR_PTR_SEL: ptr_sel_reg <= sfr_wdata;
            mmd_pkg::SFR_PAGE: page_reg <= sfr_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         unique case (sfr_addr)
            mmd_pkg::SFR_PTR0_LO: sfr_rdata <= ptr0_lo_reg;
            mmd_pkg::SFR_PTR0_HI: sfr_rdata <= ptr0_hi_reg;
            mmd_pkg::SFR_PTR1_LO: sfr_rdata <= ptr1_lo_reg;
            mmd_pkg::SFR_PTR1_HI: sfr_rdata <= ptr1_hi_reg;
            mmd_pkg::SFR_PTR_SEL: sfr_rdata <= ptr_sel_reg;
            mmd_pkg::SFR_PAGE: sfr_rdata <= page_reg;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // core reset hold; strap sampled only after sync settles
   always_ff @(posedge clock) begin
      if (rst) begin
         core_reset <= 1'b1;
         boot_cnt_reg <= 2'h0;
         boot_done_reg <= 1'b0;
      end else begin
         if (!boot_done_reg) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
         end
         if (!boot_done_reg && boot_cnt_reg == 2'(mmd_pkg::BOOT_WAIT)) begin
            boot_done_reg <= 1'b1;
            if (nvm_s2_reg) begin
               core_reset <= 1'b0;
            end
         end
         // host write wins over the strap release in the same cycle
         if (host_hold_write) begin
            core_reset <= host_hold_value;
         end
      end
   end

   // external pins; strobes only for external regions
   assign pins_on = (state_reg == ST_STROBE) && is_ext_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         ext_addr <= 16'h0000;
         ext_data_out <= 8'h00;
         ext_data_oe <= 1'b0;
         code_fetch_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         chip_select_n <= 1'b1;
         output_enable_n <= 1'b1;
      end else begin
         ext_addr <= acc_addr_reg;
         ext_data_out <= acc_wdata_reg;
         ext_data_oe <= pins_on && is_wr_reg;
         code_fetch_strobe_n <= !(pins_on && is_code_reg);
         // port c bits carry the data strobes only when expanding
         if (expansion_enable) begin
            read_strobe_n <= !(pins_on && !is_code_reg && !is_wr_reg);
            write_strobe_n <= !(pins_on && is_wr_reg);
         end else begin
            read_strobe_n <= port_c_bit_seven;
            write_strobe_n <= port_c_bit_six;
         end
         chip_select_n <= !pins_on;
         output_enable_n <= !(pins_on && !is_wr_reg);
      end
   end

   // checks
   sequence s_start;
      state_reg == ST_IDLE && core_req && !core_reset;
   endsequence
   sequence s_ack_at_end;
      ##ACC_CLOCKS core_ack;
   endsequence

   chk_access_length: assert property (@(posedge clock) disable iff (rst)
      s_start |=> s_ack_at_end)
      else $error("access did not finish in eight clocks");
   chk_low_ram_int: assert property (@(posedge clock) disable iff (rst)
      s_start and !core_code && core_addr <= mmd_pkg::RAM_HI &&
      core_mode == mmd_pkg::MMD_ADDR_DIRECT
      |-> ##ACC_CLOCKS (chip_select_n && int_region ==
                        mmd_pkg::MMD_REG_RAM))
      else $error("low ram access reached the pins");
   chk_ea_fetch: assert property (@(posedge clock) disable iff (rst)
      s_start and core_code && ea_s2_reg
      |-> ##6 !code_fetch_strobe_n)
      else $error("fetch with select high not external");
   chk_ea_low_gate: assert property (@(posedge clock) disable iff (rst)
      s_start and core_code && !ea_s2_reg && core_addr <= mmd_pkg::RAM_HI
      |-> ##1 code_fetch_strobe_n [*8])
      else $error("fetch strobe below 1b40 with select low");
   chk_bulk_ctrl: assert property (@(posedge clock) disable iff (rst)
      s_start and !core_code && eff_addr >= mmd_pkg::BULK_LO
      && eff_addr <= mmd_pkg::CTRL_HI
      |-> ##1 (region_reg == mmd_pkg::MMD_REG_BULK ||
               region_reg == mmd_pkg::MMD_REG_CTRL))
      else $error("buffer or control window decoded external");
   chk_iso_window: assert property (@(posedge clock) disable iff (rst)
      s_start and !core_code && iso_disable_bit &&
      eff_addr >= mmd_pkg::ISO_LO && eff_addr <= mmd_pkg::ISO_HI
      |-> ##1 !is_ext_reg ##6 read_strobe_n && chip_select_n)
      else $error("strobes for iso ram while disabled");
   chk_select_combo: assert property (@(posedge clock) disable iff (rst)
      expansion_enable && $past(expansion_enable)
      |-> chip_select_n == (read_strobe_n && write_strobe_n &&
                            code_fetch_strobe_n))
      else $error("chip select does not follow strobes");
   chk_oe_combo: assert property (@(posedge clock) disable iff (rst)
      expansion_enable && $past(expansion_enable)
      |-> output_enable_n == (read_strobe_n && code_fetch_strobe_n))
      else $error("output enable does not follow strobes");
   chk_port_c_share: assert property (@(posedge clock) disable iff (rst)
      !expansion_enable |=> read_strobe_n == $past(port_c_bit_seven)
      && write_strobe_n == $past(port_c_bit_six))
      else $error("port c bits not passed through");
   chk_page_addr: assert property (@(posedge clock) disable iff (rst)
      s_start and core_mode == mmd_pkg::MMD_ADDR_PAGED
      |-> ##2 ext_addr == {$past(page_reg, 2), $past(core_addr[7:0], 2)})
      else $error("paged access lost the page byte");
   chk_pointer_pick: assert property (@(posedge clock) disable iff (rst)
      s_start and core_mode == mmd_pkg::MMD_ADDR_POINTER && ptr_sel_reg[0]
      |=> acc_addr_reg == {$past(ptr1_hi_reg), $past(ptr1_lo_reg)})
      else $error("pointer select ignored");
   chk_host_hold: assert property (@(posedge clock) disable iff (rst)
      host_hold_write |=> core_reset == $past(host_hold_value))
      else $error("host hold bit not applied");
   chk_boot_hold: assert property (@(posedge clock)
      rst |=> core_reset [*4])
      else $error("core left reset before strap sampled");
   chk_iso_reset: assert property (@(posedge clock)
      rst |=> !iso_disable_bit)
      else $error("iso disable not zero after reset");
endmodule : mmd_bus
`default_nettype wire

// File: mmd_ext_mem.sv
/*
 * mmd_ext_mem: external code and data memory on the expansion bus.
 * Assumes active-low select, enable and write strobe from the bus block.
 */
`timescale 1ns/100ps
`default_nettype none
module mmd_ext_mem #(
   parameter int DATA_DELAY = 1
) (
   input wire logic clock,
   input wire logic [15:0] ext_addr,
   input wire logic [7:0] ext_data_out,
   input wire logic ext_data_oe,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   output logic [7:0] ext_data_in
);
   logic [7:0] mem_reg [0:65535];
   logic [7:0] last_reg;
   initial begin
      // fill pattern is arbitrary
      for (int i = 0; i < 65536; i++) begin
         mem_reg[i] = i[7:0] ^ i[15:8];
      end
      last_reg = 8'h00;
      ext_data_in = 8'hff;
   end
   // no pull-ups: a released bus shows the inverse of the last byte
   always @(chip_select_n or output_enable_n or ext_addr) begin
      if (!chip_select_n && !output_enable_n) begin
         last_reg = mem_reg[ext_addr];
         ext_data_in <= #DATA_DELAY last_reg;
      end else begin
         ext_data_in <= ~last_reg;
      end
   end
   always @(posedge clock) begin
      if (!chip_select_n && !write_strobe_n && ext_data_oe) begin
         mem_reg[ext_addr] <= ext_data_out;
      end
   end
endmodule : mmd_ext_mem
`default_nettype wire

// File: mmd_tb.sv
/*
 * tb: self-checking bench for mmd_bus with an external memory model.
 * Assumes mmd_pkg, mmd_bus and mmd_ext_mem are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic [4:0] strb;
      logic [3:0] place;
      logic rd;
   } mmd_note_type;
   logic clock, rst, external_code_select, nvm_boot_strap, expansion_enable;
   logic port_c_bit_seven, port_c_bit_six, host_hold_write, host_hold_value;
   logic core_req, core_code, core_write, core_busy, core_ack, core_reset;
   logic [1:0] core_mode;
   logic [15:0] core_addr, int_addr, ext_addr, got_addr;
   logic [7:0] core_wdata, core_rdata, sfr_addr, sfr_wdata, sfr_rdata;
   logic [7:0] int_rdata, int_wdata, ext_data_out, ext_data_in;
   logic sfr_write, int_req, int_we, iso_disable_bit, ext_data_oe;
   logic [2:0] int_region;
   logic code_fetch_strobe_n, read_strobe_n, write_strobe_n;
   logic chip_select_n, output_enable_n;
   logic [4:0] pins, prev_pins, seen;
   logic [3:0] got_place;
   int mismatches = 0;
   int num_checks = 0;
   integer seed = 32'h0916068d;
   mmd_note_type notes[$];
   logic [7:0] shadow [logic [15:0]];
   localparam logic [7:0] sfr_map [7] = '{mmd_pkg::SFR_PTR0_LO,
      mmd_pkg::SFR_PTR0_HI, mmd_pkg::SFR_PTR1_LO, mmd_pkg::SFR_PTR1_HI,
      mmd_pkg::SFR_PTR_SEL, mmd_pkg::SFR_PAGE, 8'h87};
   // entry: code, write, region, address
   localparam logic [20:0] acc_tab [19] = '{{5'b10001, 16'h0100},
      {5'b00001, 16'h1b3f}, {5'b01001, 16'h0100}, {5'b00010, 16'h1b40},
      {5'b01010, 16'h1f3f}, {5'b00010, 16'h7b40}, {5'b01010, 16'h7f3f},
      {5'b00011, 16'h7f40}, {5'b00011, 16'h7fff}, {5'b00000, 16'h2000},
      {5'b10000, 16'h4000}, {5'b01000, 16'h8001}, {5'b00000, 16'h8001},
      {5'b00000, 16'hffff}, {5'b00100, 16'h2000}, {5'b01100, 16'h27ff},
      {5'b00000, 16'h2800}, {5'b10000, 16'h0100}, {5'b00001, 16'h0100}};

   mmd_bus #(.RAM_8K(1'b1)) i_dut (.clock, .rst, .external_code_select,
      .nvm_boot_strap, .expansion_enable, .port_c_bit_seven, .port_c_bit_six,
      .host_hold_write, .host_hold_value, .core_req, .core_code, .core_write,
      .core_mode, .core_addr, .core_wdata, .core_busy, .core_ack, .core_rdata,
      .core_reset, .sfr_write, .sfr_addr, .sfr_wdata, .sfr_rdata, .int_req,
      .int_we, .int_region, .int_addr, .int_wdata, .int_rdata,
      .iso_disable_bit, .ext_addr, .ext_data_out, .ext_data_oe, .ext_data_in,
      .code_fetch_strobe_n, .read_strobe_n, .write_strobe_n, .chip_select_n,
      .output_enable_n);
   mmd_ext_mem #(.DATA_DELAY(3)) i_mem (.clock, .ext_addr, .ext_data_out,
      .ext_data_oe, .chip_select_n, .output_enable_n, .write_strobe_n,
      .ext_data_in);

   initial clock = 1'b0;
   always #2 clock = ~clock;

   task automatic check_value(input string what, input logic [15:0] got,
         input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what,
            got, exp);
      end
   endtask : check_value

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   function automatic logic [7:0] exp_ext(input logic [15:0] a);
      return shadow.exists(a) ? shadow[a] : a[7:0] ^ a[15:8];
   endfunction : exp_ext

   // the next request goes out in the ack cycle, so accesses run back to back
   task automatic access(input logic code, wr, input logic [1:0] mode,
         input logic [15:0] a, ea, input logic [2:0] region,
         input logic [7:0] wd);
      mmd_note_type n;
      logic [7:0] r;
      r = 8'($random(seed));
      n.addr = ea;
      n.rd = code | ~wr;
      n.place = {wr & ~code & (region != 3'd0), region};
      n.strb = region != 3'd0 ? 5'h00 : code ? 5'b10011 :
         wr ? 5'b00110 : 5'b01011;
      n.data = wr & ~code ? wd : region != 3'd0 ? r : exp_ext(ea);
      if (region == 3'd0 && wr && !code) shadow[ea] = wd;
      notes.push_back(n);
      core_req <= 1'b1;
      core_code <= code;
      core_write <= wr;
      core_mode <= mode;
      core_addr <= a;
      core_wdata <= wd;
      int_rdata <= r;
      @(posedge clock);
      core_req <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : access

   task automatic run(input int lo, hi);
      for (int i = lo; i <= hi; i++) begin
         access(acc_tab[i][20], acc_tab[i][19], 2'd0, acc_tab[i][15:0],
            acc_tab[i][15:0], acc_tab[i][18:16], 8'($random(seed)));
      end
   endtask : run

   task automatic sfr_put(input logic [7:0] a, d);
      sfr_write <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clock);
      sfr_write <= 1'b0;
      @(posedge clock);
   endtask : sfr_put

   task automatic sfr_check(input logic [7:0] a, exp);
      sfr_addr <= a;
      repeat (2) @(posedge clock);
      check_value("sfr", sfr_rdata, exp);
   endtask : sfr_check

   task automatic end_test(input string s);
      $display("test %s done at %0t", s, $time);
   endtask : end_test

   assign pins = {code_fetch_strobe_n, read_strobe_n, write_strobe_n,
      chip_select_n, output_enable_n};
   always @(posedge clock) begin
      mmd_note_type n;
      if (rst) begin
         seen = '0;
         got_place = '0;
      end else begin
         if (core_busy === 1'b1 && (prev_pins & ~pins) != 5'h00) begin
            seen = seen | (prev_pins & ~pins);
            got_addr = ext_addr;
         end
         if (int_req === 1'b1) begin
            got_place = {int_we, int_region};
            check_value("int addr", int_addr, notes[0].addr);
            if (int_we === 1'b1) begin
               check_value("int dat", int_wdata, notes[0].data);
            end
         end
         if (core_ack === 1'b1) begin
            if (notes.size() == 0) begin
               check_value("stray ack", 16'h1, 16'h0);
            end else begin
               n = notes.pop_front();
               check_value("strobes", seen, n.strb);
               check_value("place", got_place, n.place);
               if (n.strb != 5'h00) check_value("addr", got_addr, n.addr);
               if (n.rd) check_value("data", core_rdata, n.data);
            end
            seen = '0;
            got_place = '0;
         end
      end
      prev_pins = pins;
   end

   initial begin
      repeat (20000) @(posedge clock);
      check_value("timeout", 16'h1, 16'h0);
      complete_run();
   end

   initial begin
      logic [15:0] a;
      logic [7:0] v [7];
      rst = 1'b1;
      external_code_select = 1'b0;
      nvm_boot_strap = 1'b0;
      expansion_enable = 1'b1;
      port_c_bit_seven = 1'b1;
      port_c_bit_six = 1'b1;
      host_hold_write = 1'b0;
      host_hold_value = 1'b0;
      core_req = 1'b0;
      core_code = 1'b0;
      core_write = 1'b0;
      core_mode = 2'd0;
      core_addr = 16'h0000;
      core_wdata = 8'h00;
      sfr_write = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      int_rdata = 8'h00;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (10) @(posedge clock);
      check_value("held", core_reset, 16'h1);
      check_value("iso reset", iso_disable_bit, 16'h0);
      core_req <= 1'b1;
      @(posedge clock);
      core_req <= 1'b0;
      repeat (3) @(posedge clock);
      check_value("refused", core_busy, 16'h0);
      host_hold_write <= 1'b1;
      @(posedge clock);
      host_hold_write <= 1'b0;
      @(posedge clock);
      check_value("released", core_reset, 16'h0);
      end_test("boot hold");
      for (int i = 0; i < 7; i++) sfr_check(sfr_map[i], 8'h00);
      for (int i = 0; i < 7; i++) begin
         v[i] = 8'($random(seed));
         sfr_put(sfr_map[i], v[i]);
      end
      for (int i = 0; i < 7; i++) sfr_check(sfr_map[i], i == 6 ? 8'h00 : v[i]);
      end_test("sfr");
      sfr_put(mmd_pkg::SFR_PTR0_HI, 8'h90);
      sfr_put(mmd_pkg::SFR_PTR0_LO, 8'h12);
      sfr_put(mmd_pkg::SFR_PTR1_HI, 8'ha0);
      sfr_put(mmd_pkg::SFR_PTR1_LO, 8'h34);
      sfr_put(mmd_pkg::SFR_PAGE, 8'hc5);
      for (int s = 0; s < 4; s++) begin
         sfr_put(mmd_pkg::SFR_PTR_SEL, 8'(s));
         access(1'b0, s[1], 2'd1, 16'h0000, s[0] ? 16'ha034 : 16'h9012,
            3'd0, 8'($random(seed)));
      end
      access(1'b0, 1'b0, 2'd2, 16'h3377, 16'hc577, 3'd0, 8'h00);
      end_test("pointers");
      run(0, 13);
      for (int i = 0; i < 4; i++) begin
         a = {1'b1, 15'($random(seed))};
         access(1'b0, 1'b1, 2'd0, a, a, 3'd0, 8'($random(seed)));
         access(1'b0, 1'b0, 2'd0, a, a, 3'd0, 8'h00);
      end
      end_test("decode");
      access(1'b0, 1'b1, 2'd0, mmd_pkg::ISO_CTRL_ADDR, mmd_pkg::ISO_CTRL_ADDR,
         3'd3, 8'h01);
      repeat (2) @(posedge clock);
      check_value("iso set", iso_disable_bit, 16'h1);
      run(14, 16);
      access(1'b0, 1'b1, 2'd0, mmd_pkg::ISO_CTRL_ADDR, mmd_pkg::ISO_CTRL_ADDR,
         3'd3, 8'h00);
      repeat (2) @(posedge clock);
      check_value("iso clear", iso_disable_bit, 16'h0);
      end_test("iso");
      external_code_select <= 1'b1;
      repeat (4) @(posedge clock);
      run(17, 18);
      external_code_select <= 1'b0;
      repeat (4) @(posedge clock);
      end_test("code select");
      expansion_enable <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         port_c_bit_seven <= i[0];
         port_c_bit_six <= ~i[0];
         repeat (3) @(posedge clock);
         check_value("port c7", read_strobe_n, 16'(i[0]));
         check_value("port c6", write_strobe_n, {15'h0, ~i[0]});
      end
      port_c_bit_seven <= 1'b1;
      port_c_bit_six <= 1'b1;
      expansion_enable <= 1'b1;
      repeat (3) @(posedge clock);
      end_test("port c");
      rst <= 1'b1;
      nvm_boot_strap <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      check_value("strap held", core_reset, 16'h1);
      repeat (4) @(posedge clock);
      check_value("strap free", core_reset, 16'h0);
      access(1'b0, 1'b0, 2'd0, 16'h5555, 16'h5555, 3'd0, 8'h00);
      for (int i = 0; i < 40 && notes.size() != 0; i++) @(posedge clock);
      check_value("drained", 16'(notes.size()), 16'h0);
      end_test("strap boot");
      complete_run();
   end
endmodule : tb
`default_nettype wire
